// File: rfct_map.vh
// Register map and timing constants of the frontend countdown timers.
// Assumes an 8-bit register port with byte offsets as printed.
`ifndef RFCT_MAP_VH
`define RFCT_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define RFCT_ADDR_RUN_CTRL 7'h0e
`define RFCT_ADDR_T0_CTRL 7'h0f
`define RFCT_ADDR_T0_RELOAD_UPPER 7'h10
`define RFCT_ADDR_T0_RELOAD_LOWER 7'h11
`define RFCT_ADDR_T0_COUNT_UPPER 7'h12
`define RFCT_ADDR_T0_COUNT_LOWER 7'h13
`define RFCT_ADDR_T1_CTRL 7'h14
`define RFCT_ADDR_T1_RELOAD_UPPER 7'h15
`define RFCT_ADDR_T1_RELOAD_LOWER 7'h16
`define RFCT_ADDR_T1_COUNT_UPPER 7'h17
`define RFCT_ADDR_T1_COUNT_LOWER 7'h18
`define RFCT_ADDR_IRQ_STATUS 7'h30
`define RFCT_ADDR_IRQ_MASK 7'h31
// ****************************************
// Control field positions
// ****************************************
`define RFCT_STOP_RX_BIT 7
`define RFCT_START_HI 5
`define RFCT_START_LO 4
`define RFCT_RESTART_BIT 3
`define RFCT_CLK_HI 1
`define RFCT_CLK_LO 0
`define RFCT_CTRL_WMASK 8'hbb
`define RFCT_T0_RUN_BIT 4
`define RFCT_T1_RUN_BIT 5
`define RFCT_T0_MASK_BIT 0
`define RFCT_T1_MASK_BIT 1
// ****************************************
// Start modes and clock sources
// ****************************************
`define RFCT_START_NONE 2'h0
`define RFCT_START_TX_END 2'h1
`define RFCT_START_TRIM 2'h2
`define RFCT_START_TRIM_UF 2'h3
`define RFCT_CLK_FAST 2'h0
`define RFCT_CLK_SLOW 2'h1
`define RFCT_CLK_CASC_A 2'h2
`define RFCT_CLK_CASC_B 2'h3
// ****************************************
// Reset values and timing
// ****************************************
`define RFCT_RESET_BYTE 8'h00
`define RFCT_RX_STOP_BITS 3'h4
`define RFCT_SLOW_CLK_DIV 7'h40
`endif

// File: rfct_edge_sync.v
// Two-flop synchroniser with rising edge pulse for an asynchronous pin.
// Assumes the pin level stays stable for at least two clock periods.
module rfct_edge_sync (
  input wire clock_i,
  input wire rstn_i,
  input wire pin_i,
  output wire level_o,
  output wire rise_o
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign level_o = sync_q;
  assign rise_o = sync_q & ~last_q;
endmodule // rfct_edge_sync

// File: rfct_countdown.v
// One 16-bit countdown timer with reload, auto restart and start modes.
// Assumes tick_i, start and stop pulses are one clock wide on clock_i.
`include "rfct_map.vh"
module rfct_countdown (
  input wire clock_i,
  input wire rstn_i,
  input wire [7:0] ctrl_i,
  input wire [15:0] reload_i,
  input wire tick_i,
  input wire sw_start_i,
  input wire sw_stop_i,
  input wire tx_end_i,
  input wire rx_bits_i,
  input wire trim_rise_i,
  output reg running_o,
  output reg underflow_o,
  output reg [15:0] count_o
);
  wire [1:0] mode;
  wire trim;
  wire auto_start;
  wire start;
  wire stop;
  assign mode = ctrl_i[`RFCT_START_HI:`RFCT_START_LO];
  assign trim = mode[1];
  // In the trimming modes the same rising edge starts an idle timer and stops a running one.
  assign auto_start = (mode == `RFCT_START_TX_END && tx_end_i) || (trim && trim_rise_i && !running_o); // [R07]
  assign start = sw_start_i | auto_start;
  assign stop = sw_stop_i | (trim && trim_rise_i && running_o)
    | (!trim && ctrl_i[`RFCT_STOP_RX_BIT] && rx_bits_i); // [R05] [R06] [R07]
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      running_o <= 1'b0;
      underflow_o <= 1'b0;
      count_o <= 16'h0000;
    end else begin
      underflow_o <= 1'b0;
      if (start) begin
        count_o <= reload_i; // [R01] [R02]
        running_o <= 1'b1;
      end else if (stop) begin
        running_o <= 1'b0;
      end else if (running_o && tick_i) begin
        if (count_o == 16'h0000) begin
          // Trimming without underflow passes zero silently, with no underflow pulse; restart or stop still applies.
          underflow_o <= (mode != `RFCT_START_TRIM);
          if (ctrl_i[`RFCT_RESTART_BIT]) begin
            count_o <= reload_i; // [R08]
          end else begin
            running_o <= 1'b0; // [R08]
          end
        end else begin
          count_o <= count_o - 16'h0001;
        end
      end
    end
  end
endmodule // rfct_countdown

// File: rfct_timers.v
// Two cascadable 16-bit countdown timers of a contactless reader frontend.
// Assumes an 8-bit register port and asynchronous event pins from the RF logic.
// Notes on behaviour
// R01: A start event loads the 16-bit count from both reload bytes together.
// R02: Writing a reload byte leaves a running count alone until the next start.
// R03: First timer count readable at 12h high and 13h low, hardware updated.
// R04: Software should not read count bytes during reception.
// R05: Stop-on-receive set halts the timer after the first four received bits.
// R06: Stop-on-receive is ignored while a trimming start mode is selected.
// R07: Start modes: none, at transmit end, trimming, trimming with underflow.
// R08: Auto restart reloads after zero; otherwise the timer stops at zero.
// R09: Second timer underflow sets its interrupt request flag.
// R10: Second timer clock: fast, slow, first timer or third timer underflow.
// R11: Second timer control at 14h, reserved bits 6 and 2; reloads at 15h, 16h.
// R12: Run bits 7 to 4 change only where mask bits 3 to 0 are written one.
// R13: Run bits show counting state; writing them with mask starts or stops.
// R14: First timer clock: fast, slow, third timer or second timer underflow.
// R15: Reserved control bits read zero and ignore writes.
`include "rfct_map.vh"
module rfct_timers #(
  parameter SLOW_DIV = `RFCT_SLOW_CLK_DIV
) (
  input wire clock_i,
  input wire rstn_i,
  input wire [6:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire fast_tick_pin_i,
  input wire tx_end_pin_i,
  input wire rx_bits_pin_i,
  input wire trim_pin_i,
  input wire third_uf_pin_i,
  output reg [7:0] rdata_o,
  output reg irq_o,
  output reg t0_running_o,
  output reg t1_running_o
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  wire fast_rise;
  wire tx_rise;
  wire rx_rise;
  wire trim_rise;
  wire third_rise;
  rfct_edge_sync u_fast (.clock_i(clock_i), .rstn_i(rstn_i), .pin_i(fast_tick_pin_i), .level_o(), .rise_o(fast_rise));
  rfct_edge_sync u_tx (.clock_i(clock_i), .rstn_i(rstn_i), .pin_i(tx_end_pin_i), .level_o(), .rise_o(tx_rise));
  rfct_edge_sync u_rx (.clock_i(clock_i), .rstn_i(rstn_i), .pin_i(rx_bits_pin_i), .level_o(), .rise_o(rx_rise));
  rfct_edge_sync u_trim (.clock_i(clock_i), .rstn_i(rstn_i), .pin_i(trim_pin_i), .level_o(), .rise_o(trim_rise));
  rfct_edge_sync u_third (.clock_i(clock_i), .rstn_i(rstn_i), .pin_i(third_uf_pin_i), .level_o(), .rise_o(third_rise));

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] t0_ctrl_q;
  reg [7:0] t0_rel_hi_q;
  reg [7:0] t0_rel_lo_q;
  reg [7:0] t1_ctrl_q;
  reg [7:0] t1_rel_hi_q;
  reg [7:0] t1_rel_lo_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg [6:0] div_q;
  reg slow_tick_q;
  reg [2:0] rx_cnt_q;
  reg rx_hit_q;
  wire t0_run;
  wire t1_run;
  wire t0_uf;
  wire t1_uf;
  wire [15:0] t0_count;
  wire [15:0] t1_count;
  wire wr_run;
  wire [1:0] irq_set;
  wire [1:0] irq_clr;

  // The clock select codes differ per timer only in the two cascade sources.
  function clk_pick;
    input [1:0] sel;
    input fast;
    input slow;
    input casc_a;
    input casc_b;
    begin
      case (sel)
        `RFCT_CLK_FAST: clk_pick = fast;
        `RFCT_CLK_SLOW: clk_pick = slow;
        `RFCT_CLK_CASC_A: clk_pick = casc_a;
        `RFCT_CLK_CASC_B: clk_pick = casc_b;
        default: clk_pick = 1'b0;
      endcase
    end
  endfunction

  assign wr_run = wr_i && (addr_i == `RFCT_ADDR_RUN_CTRL);

  // ****************************************
  // Slow tick divider
  // ****************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= 7'h00;
      slow_tick_q <= 1'b0;
    end else begin
      slow_tick_q <= 1'b0;
      if (fast_rise) begin
        if (div_q == SLOW_DIV - 7'h01) begin
          div_q <= 7'h00;
          slow_tick_q <= 1'b1;
        end else begin
          div_q <= div_q + 7'h01;
        end
      end
    end
  end

  // ****************************************
  // Received bit counter
  // ****************************************
  // Counts bit strobes after each transmit end; one hit pulse at the fourth.
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_cnt_q <= 3'h0;
      rx_hit_q <= 1'b0;
    end else begin
      rx_hit_q <= 1'b0;
      if (tx_rise) begin
        rx_cnt_q <= 3'h0;
      end else if (rx_rise && rx_cnt_q != `RFCT_RX_STOP_BITS) begin
        rx_cnt_q <= rx_cnt_q + 3'h1;
        rx_hit_q <= (rx_cnt_q == `RFCT_RX_STOP_BITS - 3'h1); // [R05]
      end
    end
  end

  // ****************************************
  // Timers
  // ****************************************
  rfct_countdown u_t0 (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ctrl_i(t0_ctrl_q),
    .reload_i({t0_rel_hi_q, t0_rel_lo_q}),
    .tick_i(clk_pick(t0_ctrl_q[`RFCT_CLK_HI:`RFCT_CLK_LO], fast_rise, slow_tick_q, third_rise, t1_uf)), // [R14]
    .sw_start_i(wr_run && wdata_i[`RFCT_T0_MASK_BIT] && wdata_i[`RFCT_T0_RUN_BIT]), // [R12] [R13]
    .sw_stop_i(wr_run && wdata_i[`RFCT_T0_MASK_BIT] && !wdata_i[`RFCT_T0_RUN_BIT]), // [R12] [R13]
    .tx_end_i(tx_rise),
    .rx_bits_i(rx_hit_q),
    .trim_rise_i(trim_rise),
    .running_o(t0_run),
    .underflow_o(t0_uf),
    .count_o(t0_count)
  );

  rfct_countdown u_t1 (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ctrl_i(t1_ctrl_q),
    .reload_i({t1_rel_hi_q, t1_rel_lo_q}),
    .tick_i(clk_pick(t1_ctrl_q[`RFCT_CLK_HI:`RFCT_CLK_LO], fast_rise, slow_tick_q, t0_uf, third_rise)), // [R10]
    .sw_start_i(wr_run && wdata_i[`RFCT_T1_MASK_BIT] && wdata_i[`RFCT_T1_RUN_BIT]), // [R12] [R13]
    .sw_stop_i(wr_run && wdata_i[`RFCT_T1_MASK_BIT] && !wdata_i[`RFCT_T1_RUN_BIT]), // [R12] [R13]
    .tx_end_i(tx_rise),
    .rx_bits_i(rx_hit_q),
    .trim_rise_i(trim_rise),
    .running_o(t1_run),
    .underflow_o(t1_uf),
    .count_o(t1_count)
  );

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      t0_ctrl_q <= `RFCT_RESET_BYTE;
      t0_rel_hi_q <= `RFCT_RESET_BYTE;
      t0_rel_lo_q <= `RFCT_RESET_BYTE;
      t1_ctrl_q <= `RFCT_RESET_BYTE;
      t1_rel_hi_q <= `RFCT_RESET_BYTE;
      t1_rel_lo_q <= `RFCT_RESET_BYTE;
      irq_mask_q <= 2'h0;
    end else if (wr_i) begin
      case (addr_i)
        `RFCT_ADDR_T0_CTRL: t0_ctrl_q <= wdata_i & `RFCT_CTRL_WMASK; // [R15]
        `RFCT_ADDR_T0_RELOAD_UPPER: t0_rel_hi_q <= wdata_i; // [R02]
        `RFCT_ADDR_T0_RELOAD_LOWER: t0_rel_lo_q <= wdata_i; // [R02]
        `RFCT_ADDR_T1_CTRL: t1_ctrl_q <= wdata_i & `RFCT_CTRL_WMASK; // [R11] [R15]
        `RFCT_ADDR_T1_RELOAD_UPPER: t1_rel_hi_q <= wdata_i; // [R11]
        `RFCT_ADDR_T1_RELOAD_LOWER: t1_rel_lo_q <= wdata_i; // [R11]
        `RFCT_ADDR_IRQ_MASK: irq_mask_q <= wdata_i[1:0];
        default: t0_ctrl_q <= t0_ctrl_q;
      endcase
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  // Bit 1 is the second timer underflow flag, bit 0 the first timer's.
  // A new underflow wins over a write-one-to-clear in the same cycle.
  assign irq_set = {t1_uf, t0_uf}; // [R09]
  assign irq_clr = (wr_i && addr_i == `RFCT_ADDR_IRQ_STATUS) ? wdata_i[1:0] : 2'h0;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_q <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set; // [R09]
      irq_o <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
    end
  end

  // ****************************************
  // Register reads and run outputs
  // ****************************************
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
      t0_running_o <= 1'b0;
      t1_running_o <= 1'b0;
    end else begin
      t0_running_o <= t0_run;
      t1_running_o <= t1_run;
      rdata_o <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `RFCT_ADDR_RUN_CTRL: rdata_o <= {2'h0, t1_run, t0_run, 4'h0}; // [R13]
          `RFCT_ADDR_T0_CTRL: rdata_o <= t0_ctrl_q;
          `RFCT_ADDR_T0_RELOAD_UPPER: rdata_o <= t0_rel_hi_q;
          `RFCT_ADDR_T0_RELOAD_LOWER: rdata_o <= t0_rel_lo_q;
          `RFCT_ADDR_T0_COUNT_UPPER: rdata_o <= t0_count[15:8]; // [R03]
          `RFCT_ADDR_T0_COUNT_LOWER: rdata_o <= t0_count[7:0]; // [R03]
          `RFCT_ADDR_T1_CTRL: rdata_o <= t1_ctrl_q; // [R15]
          `RFCT_ADDR_T1_RELOAD_UPPER: rdata_o <= t1_rel_hi_q;
          `RFCT_ADDR_T1_RELOAD_LOWER: rdata_o <= t1_rel_lo_q;
          `RFCT_ADDR_T1_COUNT_UPPER: rdata_o <= t1_count[15:8];
          `RFCT_ADDR_T1_COUNT_LOWER: rdata_o <= t1_count[7:0];
          `RFCT_ADDR_IRQ_STATUS: rdata_o <= {6'h00, irq_stat_q};
          `RFCT_ADDR_IRQ_MASK: rdata_o <= {6'h00, irq_mask_q};
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule // rfct_timers

// File: rfct_timers_checker.sv
// Port-level assertions for the two countdown timers.
// Assumes it is bound to the timer top module and sees only its ports.
module rfct_timers_checker (
  input wire clock_i,
  input wire rstn_i,
  input wire [6:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire irq_o,
  input wire t0_running_o,
  input wire t1_running_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence reload_wr_rd;
    wr_i && addr_i inside {7'h10, 7'h11, 7'h15, 7'h16} ##1 rd_i && addr_i == $past(addr_i);
  endsequence
  sequence mask_off;
    wr_i && addr_i == 7'h31 && wdata_i == 8'h00 ##1 !(wr_i && addr_i == 7'h31);
  endsequence
  chk_reload_readback: assert property (reload_wr_rd |=> rdata_o == $past(wdata_i, 2))
    else $error("reload byte readback differs");
  chk_reserved_zero: assert property (rd_i && addr_i == 7'h14 |=> !rdata_o[6] && !rdata_o[2])
    else $error("reserved control bit reads one");
  chk_unmapped_zero: assert property (rd_i && addr_i == 7'h7f |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data without read");
  chk_irq_masked: assert property (mask_off |=> !irq_o)
    else $error("interrupt high with mask clear");
  chk_irq_status: assert property (rd_i && addr_i == 7'h30 && irq_o |=> rdata_o[1:0] != 2'h0)
    else $error("interrupt high with empty status");
  chk_t1_start: assert property (wr_i && addr_i == 7'h0e && wdata_i[5] && wdata_i[1] |=> ##1 t1_running_o)
    else $error("second timer did not start");
  chk_t1_stop: assert property (wr_i && addr_i == 7'h0e && !wdata_i[5] && wdata_i[1] |=> ##1 !t1_running_o)
    else $error("second timer did not stop");
  chk_t0_start: assert property (wr_i && addr_i == 7'h0e && wdata_i[4] && wdata_i[0] |=> ##1 t0_running_o)
    else $error("first timer did not start");
endmodule // rfct_timers_checker
bind rfct_timers rfct_timers_checker chk (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .t0_running_o(t0_running_o),
  .t1_running_o(t1_running_o));

// File: tb_rfct_timers.sv
// Self-checking bench for the two countdown timers.
// Assumes the design files and the checker are compiled before it.
module tb_rfct_timers;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0;
  logic [6:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic [4:0] pin = '0;
  wire [7:0] rdata_o;
  wire irq_o, t0_run, t1_run;
  int miscompares = 0, check_count = 0, cycles = 0;
  // A divider of two keeps the slow clock test short.
  rfct_timers #(.SLOW_DIV(7'h02)) dut (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .fast_tick_pin_i(pin[0]), .tx_end_pin_i(pin[1]), .rx_bits_pin_i(pin[2]),
    .trim_pin_i(pin[3]), .third_uf_pin_i(pin[4]), .rdata_o(rdata_o), .irq_o(irq_o), .t0_running_o(t0_run),
    .t1_running_o(t1_run));
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  task conclude;
    $display("%0d mismatches in %0d comparisons", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  // ****************************************
  // Bus, pin and compare tasks
  // ****************************************
  task cmp(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Entered at a clock edge; a write right after a write waits one edge so the strobe is never set twice at once.
  task wr(logic [6:0] a, logic [7:0] d);
    if (wr_i === 1'b1) @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task rd(logic [6:0] a, output logic [7:0] d);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
    d = rdata_o;
  endtask
  task rchk(logic [6:0] a, logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
  endtask
  // Count bytes are only read while no reception is under way.
  task cnt(logic [6:0] a, logic [15:0] exp);
    logic [7:0] h, l;
    rd(a, h);
    rd(a + 7'h01, l);
    cmp("count", exp, {h, l});
  endtask
  task pulse(int i, int n);
    repeat (n) begin
      @(posedge clock_i);
      pin[i] <= 1'b1;
      repeat (2) @(posedge clock_i);
      pin[i] <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
  endtask
  task st(logic [2:0] exp);
    repeat (2) @(posedge clock_i);
    cmp("irq t1 t0", {13'h0000, exp}, {13'h0000, irq_o, t1_run, t0_run});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    rchk(7'h14, 8'h00);
    wr(7'h14, 8'hff);
    rchk(7'h14, 8'hbb);
    wr(7'h15, 8'ha5);
    rchk(7'h15, 8'ha5);
    wr(7'h16, 8'h5a);
    rchk(7'h16, 8'h5a);
    rchk(7'h7f, 8'h00);
  endtask
  task t_count;
    wr(7'h0f, 8'h00);
    wr(7'h10, 8'h00);
    wr(7'h11, 8'h03);
    wr(7'h0e, 8'h10);
    st(3'b000);
    wr(7'h0e, 8'h11);
    st(3'b001);
    rchk(7'h0e, 8'h10);
    pulse(0, 2);
    cnt(7'h12, 16'h0001);
    wr(7'h10, 8'h12);
    wr(7'h11, 8'h34);
    cnt(7'h12, 16'h0001);
    pulse(0, 2);
    st(3'b000);
    rchk(7'h30, 8'h01);
    wr(7'h31, 8'h01);
    st(3'b100);
    rchk(7'h30, 8'h01);
    wr(7'h30, 8'h01);
    st(3'b000);
    wr(7'h0e, 8'h11);
    cnt(7'h12, 16'h1234);
    wr(7'h0e, 8'h01);
    wr(7'h31, 8'h00);
  endtask
  // Remaining counts after four fast ticks and three third-timer pulses, per clock code.
  task t_clk;
    logic [15:0] left [4] = '{16'h0001, 16'h0003, 16'h0004, 16'h0002};
    wr(7'h0f, 8'h08);
    wr(7'h10, 8'h00);
    wr(7'h11, 8'h03);
    wr(7'h15, 8'h00);
    wr(7'h16, 8'h05);
    for (int c = 0; c < 4; c++) begin
      wr(7'h14, {6'h00, c[1:0]});
      wr(7'h0e, 8'h33);
      pulse(0, 4);
      pulse(4, 3);
      cnt(7'h17, left[c]);
    end
    wr(7'h0e, 8'h03);
  endtask
  task t_restart;
    wr(7'h30, 8'h03);
    wr(7'h14, 8'h08);
    wr(7'h16, 8'h01);
    wr(7'h0e, 8'h22);
    pulse(0, 2);
    cnt(7'h17, 16'h0001);
    wr(7'h31, 8'h02);
    st(3'b110);
    rchk(7'h30, 8'h02);
    wr(7'h31, 8'h00);
    wr(7'h0e, 8'h02);
    wr(7'h30, 8'h02);
  endtask
  task t_modes;
    wr(7'h16, 8'hff);
    wr(7'h14, 8'h80);
    pulse(1, 1);
    st(3'b000);
    wr(7'h14, 8'h90);
    pulse(1, 1);
    pulse(2, 3);
    st(3'b010);
    pulse(2, 1);
    st(3'b000);
    wr(7'h14, 8'ha0);
    pulse(1, 1);
    pulse(3, 1);
    pulse(2, 4);
    st(3'b010);
    pulse(3, 1);
    st(3'b000);
    wr(7'h14, 8'hb0);
    pulse(3, 1);
    st(3'b010);
  endtask
  // A reset in mid-run must stop a running timer and clear the registers.
  task t_reset;
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    cmp("outputs in reset", 16'h0000, {13'h0000, irq_o, t1_run, t0_run});
    rstn_i <= 1'b1;
    @(posedge clock_i);
    rchk(7'h14, 8'h00);
    rchk(7'h16, 8'h00);
    st(3'b000);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_count();
    t_clk();
    t_restart();
    t_modes();
    t_reset();
    conclude();
  end
endmodule // tb_rfct_timers
